//--- bmam_map.svh
`ifndef BMAM_MAP_SVH
`define BMAM_MAP_SVH

// ==========================================================
// program store geometry and vectors
`define BMAM_PC_W 13
`define BMAM_PROG_AW 11
`define BMAM_PROG_DW 14
`define BMAM_PROG_DEPTH 2048
`define BMAM_RESET_VEC 13'h0000
`define BMAM_IRQ_VEC 13'h0004

// ==========================================================
// data bank geometry
`define BMAM_OFF_W 7
`define BMAM_EFF_W 9
`define BMAM_BANK_LAST 7'h7f
`define BMAM_GPR_BASE 7'h20
`define BMAM_ODD_OWN_LAST 7'h3f
`define BMAM_MIRROR_BASE 7'h70
`define BMAM_ODD_IDX_BASE 7'h60
`define BMAM_GPR_AW 7
`define BMAM_GPR_DEPTH 128

// ==========================================================
// core register offsets, present in every bank
`define BMAM_OFF_INDIRECT 7'h00
`define BMAM_OFF_PCL 7'h02
`define BMAM_OFF_STATUS 7'h03
`define BMAM_OFF_FSR 7'h04
`define BMAM_OFF_PROGRAM_COUNTER_HIGH_LATCH 7'h0a

// ==========================================================
// core status fields and reset values
`define BMAM_STAT_IRP 7
`define BMAM_STAT_RP_HI 6
`define BMAM_STAT_RP_LO 5
`define BMAM_STATUS_WMASK 8'he7
`define BMAM_STATUS_RST 8'h18
`define BMAM_FSR_RST 8'h00
`define BMAM_PROGRAM_COUNTER_HIGH_LATCH_W 5
`define BMAM_PROGRAM_COUNTER_HIGH_LATCH_RST 5'h00

`endif

//--- bmam_pkg.sv
package bmam_pkg;

    // ==========================================================
    // what a data access lands on after decode
    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_IND_SELF,
        TGT_PCL,
        TGT_STATUS,
        TGT_FSR,
        TGT_PROGRAM_COUNTER_HIGH_LATCH,
        TGT_GPR
    } bmam_target_e;

    // ==========================================================
    // fetch sequencer states
    typedef enum logic [1:0] {
        FS_RESET,
        FS_RUN
    } bmam_fetch_e;

endpackage

//--- bmam_ram.sv
`timescale 1ns/100ps
// ==========================================================
// single port pair store with registered read and a bypass load
module bmam_ram
    import bmam_pkg::*;
#(
    parameter int AW = 7,
    parameter int DW = 8,
    parameter int DEPTH = 128
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    input wire logic byp_en,
    input wire logic [DW-1:0] byp_data,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:DEPTH-1];

    // storage write, no reset on the array
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read register; bypass loads data that does not live here
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data <= '0;
        end else if (byp_en) begin
            rd_data <= byp_data;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

//--- bmam_addr_dec.sv
`timescale 1ns/100ps
`include "bmam_map.svh"
// ==========================================================
// data address decode: direct or indirect, bank, mirrors, store index
module bmam_addr_dec
    import bmam_pkg::*;
(
    input wire logic [6:0] offset,
    input wire logic [1:0] bank,
    input wire logic [7:0] pointer,
    input wire logic ptr_bank_hi,
    output bmam_target_e target,
    output logic [6:0] gpr_idx,
    output logic [8:0] eff_addr,
    output logic indirect
);

    // distance of an offset above the start of the general purpose area
    function automatic logic [6:0] above_base(input logic [6:0] off);
        above_base = off - `BMAM_GPR_BASE;
    endfunction

    logic [6:0] eff_off;
    logic odd_bank;
    logic in_gpr;
    logic odd_own;
    logic odd_mirror;
    logic gpr_hit;

    // offset zero takes the pointer as the address
    assign indirect = (offset == `BMAM_OFF_INDIRECT);
    assign eff_addr = indirect ? {ptr_bank_hi, pointer} : {bank, offset};
    assign eff_off = eff_addr[6:0];
    assign odd_bank = eff_addr[7];

    // general purpose area, odd banks own 20h-3Fh and mirror 70h-7Fh
    assign in_gpr = (eff_off >= `BMAM_GPR_BASE);
    assign odd_own = (eff_off <= `BMAM_ODD_OWN_LAST);
    assign odd_mirror = (eff_off >= `BMAM_MIRROR_BASE);
    assign gpr_hit = in_gpr && (!odd_bank || odd_own || odd_mirror);
    assign gpr_idx = (odd_bank && odd_own) ?
        (above_base(eff_off) + `BMAM_ODD_IDX_BASE) : above_base(eff_off);

    // core registers answer at one offset in all banks
    assign target =
        gpr_hit ? TGT_GPR :
        (eff_off == `BMAM_OFF_INDIRECT) ? TGT_IND_SELF :
        (eff_off == `BMAM_OFF_PCL) ? TGT_PCL :
        (eff_off == `BMAM_OFF_STATUS) ? TGT_STATUS :
        (eff_off == `BMAM_OFF_FSR) ? TGT_FSR :
        (eff_off == `BMAM_OFF_PROGRAM_COUNTER_HIGH_LATCH) ? TGT_PROGRAM_COUNTER_HIGH_LATCH : TGT_NONE;

endmodule

//--- bmam_top.sv
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "bmam_map.svh"
module bmam_top
    import bmam_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic fetch_step,
    input wire logic branch_load,
    input wire logic [10:0] branch_target,
    input wire logic irq_take,
    input wire logic prog_wr,
    input wire logic [12:0] prog_wr_addr,
    input wire logic [13:0] prog_wr_data,
    output logic [12:0] pc,
    output logic [13:0] instr_word,
    output logic instr_valid,
    output logic [1:0] bank_select_field,
    output logic [8:0] data_eff_addr,
    output logic data_unmapped
);

    // ==========================================================
    // core registers
    logic [7:0] core_status;
    logic [7:0] indirect_pointer;
    logic [`BMAM_PROGRAM_COUNTER_HIGH_LATCH_W-1:0] program_counter_high_latch;
    bmam_fetch_e fetch_state;
    bmam_fetch_e next_fetch_state;
    logic fetch_ready;
    logic [1:0] stat_bank;
    logic stat_ind_hi;
    logic [7:0] next_pointer;
    logic [`BMAM_PROGRAM_COUNTER_HIGH_LATCH_W-1:0] next_latch;
    logic next_unmapped;
    logic next_instr_valid;

    // ==========================================================
    // data side decode results
    bmam_target_e target;
    logic [6:0] gpr_idx;
    logic [8:0] eff_addr;
    logic indirect;
    logic data_access;
    logic gpr_wr;
    logic gpr_rd;
    logic sfr_rd;
    logic [7:0] sfr_rdata;

    // ==========================================================
    // register write selects
    logic wr_pcl;
    logic wr_status;
    logic wr_fsr;
    logic wr_program_counter_high_latch;
    logic [7:0] next_status;

    // ==========================================================
    // program side
    logic redirect;
    logic fetch_go;
    logic [12:0] next_pc;
    logic [12:0] pc_plus;
    logic [12:0] goto_pc;
    logic [12:0] computed_pc;
    logic [10:0] fetch_addr;
    logic [10:0] load_addr;
    logic redirect_irq;
    logic redirect_pcl;
    logic redirect_branch;

    // ==========================================================
    // status fields that steer the data decode
    // a status write moves the bank only from the next cycle on,
    // so an access beside that write still uses the old bank
    assign stat_bank = core_status[`BMAM_STAT_RP_HI:`BMAM_STAT_RP_LO];
    assign stat_ind_hi = core_status[`BMAM_STAT_IRP];

    // ==========================================================
    // data address decode
    bmam_addr_dec u_dec (
        .offset(reg_addr),
        .bank(stat_bank),
        .pointer(indirect_pointer),
        .ptr_bank_hi(stat_ind_hi),
        .target(target),
        .gpr_idx(gpr_idx),
        .eff_addr(eff_addr),
        .indirect(indirect)
    );

    // ==========================================================
    // data access steering
    assign data_access = reg_wr || reg_rd;
    assign gpr_wr = reg_wr && (target == TGT_GPR);
    assign gpr_rd = reg_rd && (target == TGT_GPR);
    assign sfr_rd = reg_rd && (target != TGT_GPR);
    assign wr_pcl = reg_wr && (target == TGT_PCL);
    assign wr_status = reg_wr && (target == TGT_STATUS);
    assign wr_fsr = reg_wr && (target == TGT_FSR);
    assign wr_program_counter_high_latch = reg_wr && (target == TGT_PROGRAM_COUNTER_HIGH_LATCH);

    // status keeps its read only flags; only the mask bits take writes
    assign next_status = (core_status & ~`BMAM_STATUS_WMASK) |
        (reg_wdata & `BMAM_STATUS_WMASK);

    // special register read value; pointer to offset zero reads zero
    // holes and reserved words read zero, so software sees them clear
    always_comb begin
        case (target)
            TGT_PCL: begin
                sfr_rdata = pc[7:0];
            end
            TGT_STATUS: begin
                sfr_rdata = core_status;
            end
            TGT_FSR: begin
                sfr_rdata = indirect_pointer;
            end
            TGT_PROGRAM_COUNTER_HIGH_LATCH: begin
                sfr_rdata = {3'h0, program_counter_high_latch};
            end
            TGT_IND_SELF: begin
                sfr_rdata = 8'h00;
            end
            default: begin
                sfr_rdata = 8'h00;
            end
        endcase
    end

    // ==========================================================
    // general purpose store; its read register drives reg_rdata
    bmam_ram #(
        .AW(`BMAM_GPR_AW),
        .DW(8),
        .DEPTH(`BMAM_GPR_DEPTH)
    ) u_gpr (
        .clk(clk),
        .rstn(rstn),
        .wr_en(gpr_wr),
        .wr_addr(gpr_idx),
        .wr_data(reg_wdata),
        .rd_en(gpr_rd),
        .rd_addr(gpr_idx),
        .byp_en(sfr_rd),
        .byp_data(sfr_rdata),
        .rd_data(reg_rdata)
    );

    // ==========================================================
    // status register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            core_status <= `BMAM_STATUS_RST;
        end else if (wr_status) begin
            core_status <= next_status;
        end
    end

    // next values of the pointer and the upper counter buffer
    assign next_pointer = wr_fsr ? reg_wdata : indirect_pointer;
    assign next_latch = wr_program_counter_high_latch ?
        reg_wdata[`BMAM_PROGRAM_COUNTER_HIGH_LATCH_W-1:0] : program_counter_high_latch;

    // indirect pointer register
    // a pointer naming offset zero reaches itself, which holds nothing
    always_ff @(posedge clk) begin
        if (!rstn) begin
            indirect_pointer <= `BMAM_FSR_RST;
        end else begin
            indirect_pointer <= next_pointer;
        end
    end

    // upper program counter write buffer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            program_counter_high_latch <= `BMAM_PROGRAM_COUNTER_HIGH_LATCH_RST;
        end else begin
            program_counter_high_latch <= next_latch;
        end
    end

    // bank select shown outside straight from the status flops
    assign bank_select_field = stat_bank;

    // an access is unmapped when it lands on no register, or on the pointer itself
    assign next_unmapped = (target == TGT_NONE) ||
        (indirect && (target == TGT_IND_SELF));

    // ==========================================================
    // last decoded data address and whether it hit nothing
    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_eff_addr <= '0;
            data_unmapped <= 1'b0;
        end else if (data_access) begin
            data_eff_addr <= eff_addr;
            data_unmapped <= next_unmapped;
        end
    end

    // ==========================================================
    // program counter candidates
    assign pc_plus = pc + 13'h0001;
    assign goto_pc = {program_counter_high_latch[4:3], branch_target};
    assign computed_pc = {program_counter_high_latch, reg_wdata};

    // redirect sources, one wire each
    assign redirect_irq = irq_take;
    assign redirect_pcl = wr_pcl;
    assign redirect_branch = branch_load;
    assign redirect = redirect_irq || redirect_pcl || redirect_branch;

    // priority: interrupt, computed jump, branch, sequential step
    always_comb begin
        if (redirect_irq) begin
            next_pc = `BMAM_IRQ_VEC;
        end else if (redirect_pcl) begin
            next_pc = computed_pc;
        end else if (redirect_branch) begin
            next_pc = goto_pc;
        end else if (fetch_go) begin
            next_pc = pc_plus;
        end else begin
            next_pc = pc;
        end
    end

    // fetch stalls in the cycle that the counter is being redirected
    // a dropped step is not replayed; the core must step again
    assign fetch_ready = (fetch_state == FS_RUN);
    assign fetch_go = fetch_step && !redirect && fetch_ready;

    // program counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pc <= `BMAM_RESET_VEC;
        end else begin
            pc <= next_pc;
        end
    end

    // fetch sequencer leaves its reset state one cycle after release
    // this keeps a step beside the release from reading a stale word
    always_comb begin
        case (fetch_state)
            FS_RESET: begin
                next_fetch_state = FS_RUN;
            end
            FS_RUN: begin
                next_fetch_state = FS_RUN;
            end
            default: begin
                next_fetch_state = FS_RESET;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fetch_state <= FS_RESET;
        end else begin
            fetch_state <= next_fetch_state;
        end
    end

    // ==========================================================
    // program store; its own port, independent of the data port
    // the top two counter bits never reach the store, so a program
    // that runs past the last word starts again at the first
    assign fetch_addr = pc[`BMAM_PROG_AW-1:0];
    assign load_addr = prog_wr_addr[`BMAM_PROG_AW-1:0];

    bmam_ram #(
        .AW(`BMAM_PROG_AW),
        .DW(`BMAM_PROG_DW),
        .DEPTH(`BMAM_PROG_DEPTH)
    ) u_prog (
        .clk(clk),
        .rstn(rstn),
        .wr_en(prog_wr),
        .wr_addr(load_addr),
        .wr_data(prog_wr_data),
        .rd_en(fetch_go),
        .rd_addr(fetch_addr),
        .byp_en(1'b0),
        .byp_data(14'h0000),
        .rd_data(instr_word)
    );

    // a word is fetched only when the step is taken
    assign next_instr_valid = fetch_go;

    // fetched word valid in the cycle after the step
    always_ff @(posedge clk) begin
        if (!rstn) begin
            instr_valid <= 1'b0;
        end else begin
            instr_valid <= next_instr_valid;
        end
    end

endmodule

//--- bmam_top_asserts.sv
`timescale 1ns/100ps
// ==========================================================
// port level checks of the banked map
module bmam_top_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic fetch_step,
    input wire logic branch_load,
    input wire logic [10:0] branch_target,
    input wire logic irq_take,
    input wire logic prog_wr,
    input wire logic [12:0] prog_wr_addr,
    input wire logic [13:0] prog_wr_data,
    input wire logic [12:0] pc,
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    input wire logic [1:0] bank_select_field,
    input wire logic [8:0] data_eff_addr,
    input wire logic data_unmapped
);
    logic run_q;
    logic pcl_wr;
    logic fetch_ok;

    // fetch is refused in the first cycle after release
    always_ff @(posedge clk) begin
        run_q <= rstn;
    end

    // a fetch counts only with no redirect beside it
    assign pcl_wr = reg_wr && (reg_addr == 7'h02);
    assign fetch_ok = fetch_step && run_q && !irq_take && !branch_load && !pcl_wr;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_reset_vector: assert property ($rose(rstn) |-> pc == 13'h0000 && !instr_valid)
        else $error("pc not at zero after reset");
    a_fetch_advance: assert property (fetch_ok |=> instr_valid && pc == $past(pc) + 13'h1)
        else $error("fetch did not answer or advance");
    a_no_stray: assert property (!fetch_ok |=> !instr_valid)
        else $error("word valid without fetch");
    a_irq_vector: assert property (irq_take |=> pc == 13'h0004)
        else $error("interrupt vector wrong");
    a_branch_low: assert property (branch_load && !irq_take && !pcl_wr |=>
        pc[10:0] == $past(branch_target))
        else $error("branch target lost");
    a_pcl_mirror: assert property (pcl_wr && !irq_take |=> pc[7:0] == $past(reg_wdata))
        else $error("low pc write lost");
    a_bank_follow: assert property (reg_wr && reg_addr == 7'h03 |=>
        bank_select_field == $past(reg_wdata[6:5]))
        else $error("bank field does not follow status");
    a_direct_decode: assert property ((reg_wr || reg_rd) && reg_addr != 7'h00 |=>
        data_eff_addr == {$past(bank_select_field), $past(reg_addr)})
        else $error("direct address decode wrong");
    a_read_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_sfr_hole: assert property (reg_rd && reg_addr == 7'h01 |=>
        reg_rdata == 8'h00 && data_unmapped)
        else $error("hole did not read zero");
endmodule

bind bmam_top bmam_top_asserts bmam_top_asserts_inst (.*);

//--- bmam_core_model.sv
`timescale 1ns/100ps
// ==========================================================
// core datapath stand-in: strobes, fetch and redirects
module bmam_core_model (
    input wire logic clk,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic fetch_step,
    output logic branch_load,
    output logic [10:0] branch_target,
    output logic irq_take
);
    // idle lines at time zero
    initial begin
        {branch_load, irq_take, fetch_step, reg_rd, reg_wr} = 5'h00;
        reg_addr = 7'h55;
        reg_wdata = 8'haa;
        branch_target = 11'h2aa;
    end

    // k is {branch, irq, fetch, read, write}; held for one edge
    // callers also write bank 3, whose store words are those of bank 1
    task automatic op(input logic [4:0] k, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        {branch_load, irq_take, fetch_step, reg_rd, reg_wr} <= k;
        reg_addr <= a;
        reg_wdata <= d;
        branch_target <= {a[2:0], d};
        @(posedge clk);
        {branch_load, irq_take, fetch_step, reg_rd, reg_wr} <= 5'h00;
        // released lines show the inverse, never the stale value
        reg_addr <= ~a;
        reg_wdata <= ~d;
        branch_target <= ~{a[2:0], d};
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clk = 0;
    logic rstn = 0;
    logic prog_wr = 0;
    logic [12:0] prog_wr_addr = 13'h0000;
    logic [13:0] prog_wr_data = 14'h0000;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, fetch_step, branch_load, irq_take, instr_valid, data_unmapped;
    logic [10:0] branch_target;
    logic [12:0] pc;
    logic [13:0] instr_word;
    logic [1:0] bank_select_field;
    logic [8:0] data_eff_addr;
    int err_total = 0;
    int n_checks = 0;

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    bmam_top bmam_top_inst (.*);
    bmam_core_model bmam_core_model_inst (.*);

    // ==========================================================
    // access tasks
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        bmam_core_model_inst.op(5'h01, a, d);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        bmam_core_model_inst.op(5'h02, a, 8'h00);
        #1;
        chk({6'h0, reg_rdata}, {6'h0, e});
    endtask

    // fetch, with a write of 3ch to offset 21h when k asks for it
    task automatic fx(input logic [4:0] k, input logic [13:0] w, input logic [12:0] p);
        bmam_core_model_inst.op(k, 7'h21, 8'h3c);
        #1;
        chk({13'h0, instr_valid}, 14'h1);
        chk(instr_word, w);
        chk({1'b0, pc}, {1'b0, p});
    endtask

    task automatic pw(input logic [12:0] a, input logic [13:0] d);
        @(posedge clk);
        prog_wr <= 1'b1;
        prog_wr_addr <= a;
        prog_wr_data <= d;
        @(posedge clk);
        prog_wr <= 1'b0;
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        test_done;
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk({1'b0, pc}, 14'h0000);
        rd(7'h03, 8'h18);
        rd(7'h04, 8'h00);
        rd(7'h0a, 8'h00);
        rd(7'h01, 8'h00);
        wr(7'h70, 8'ha5);
        wr(7'h20, 8'h11);
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, 8'(b << 5));
            rd(7'h03, 8'(b << 5) | 8'h18);
            chk({12'h0, bank_select_field}, 14'(b));
            rd(7'h70, 8'ha5);
            chk({5'h0, data_eff_addr}, 14'(b * 128 + 'h70));
        end
        wr(7'h7f, 8'hc3);
        wr(7'h20, 8'h22);
        rd(7'h20, 8'h22);
        wr(7'h03, 8'h00);
        rd(7'h7f, 8'hc3);
        rd(7'h20, 8'h11);
        wr(7'h04, 8'h20);
        wr(7'h00, 8'h5a);
        rd(7'h20, 8'h5a);
        rd(7'h00, 8'h5a);
        wr(7'h04, 8'h00);
        rd(7'h00, 8'h00);
        chk({13'h0, data_unmapped}, 14'h1);
        pw(13'h1804, 14'h1234);
        pw(13'h0005, 14'h2abc);
        pw(13'h0123, 14'h0777);
        bmam_core_model_inst.op(5'h08, 7'h00, 8'h00);
        #1;
        chk({1'b0, pc}, 14'h0004);
        fx(5'h04, 14'h1234, 13'h0005);
        fx(5'h05, 14'h2abc, 13'h0006);
        rd(7'h21, 8'h3c);
        wr(7'h0a, 8'h18);
        bmam_core_model_inst.op(5'h10, 7'h01, 8'h23);
        #1;
        chk({1'b0, pc}, 14'h1923);
        fx(5'h04, 14'h0777, 13'h1924);
        wr(7'h03, 8'h40);
        wr(7'h02, 8'hff);
        #1;
        chk({1'b0, pc}, 14'h18ff);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk({1'b0, pc}, 14'h0000);
        chk({12'h0, bank_select_field}, 14'h0000);
        test_done;
    end
endmodule
